// *** host_board_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------
// Host side of the sideband link
// ----------
module host_board_model (
  // Two-wire link
  output var logic o_scl,
  output var logic o_select_n,
  output logic o_sda,
  // Module data driver
  input wire logic i_sda_dev_o,
  input wire logic i_sda_dev_oe
);
  logic host_oe;

  // Pull-up wire: the host driver pulls it low, an enabled module driver drives i_sda_dev_o
  assign o_sda = (i_sda_dev_oe ? i_sda_dev_o : 1'b1) & ~host_oe;

  // Clock stands high and select is off outside frames
  initial begin
    o_scl = 1'b1;
    o_select_n = 1'b1;
    host_oe = 1'b0;
  end

  // One 160 ns clock pulse; data changes just after the falling edge
  task automatic pulse(input logic drv, output logic smp);
    o_scl = 1'b0;
    #10 host_oe = ~drv;
    #70 o_scl = 1'b1;
    smp = o_sda;
    #80;
  endtask

  // Whole transfer: first byte, ack slot, data byte, master ack slot
  task automatic frame(input logic sel, input logic [7:0] first, input logic [7:0] wdat,
                       output logic ack, output logic [7:0] rdat);
    logic s;
    o_select_n = ~sel;
    #80;
    repeat (2) pulse(1'b1, s);
    for (int i = 7; i >= 0; i--) pulse(first[i], s);
    pulse(1'b1, s);
    ack = ~s;
    for (int i = 7; i >= 0; i--) begin
      pulse(first[0] ? 1'b1 : wdat[i], s);
      rdat[i] = s;
    end
    pulse(1'b1, s);
    o_select_n = 1'b1;
    repeat (3) pulse(1'b1, s); // Lets the link see the deselect
  endtask
endmodule // host_board_model
`default_nettype wire

// *** optical_module_sideband_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "optical_sideband_cfg.svh"
module optical_module_sideband_ctrl #(
  parameter int RESET_MIN_CYC = `SB_RESET_MIN_CYC,
  parameter int INIT_CYC = `SB_INIT_CYC
) (
  // Core clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Host sideband pins
  input wire optical_sideband_pkg::sideband_pins_t i_pins,
  // Two-wire link
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // Open-drain interrupt and presence
  output logic o_module_interrupt_o,
  output logic o_module_interrupt_oe,
  output logic o_module_present_o,
  output logic o_module_present_oe,
  // Internal module controls
  input wire logic i_fault,
  output logic o_settings_reset,
  output logic o_high_power_en,
  output logic o_data_not_ready
);
  import optical_sideband_pkg::*;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (RESET_MIN_CYC < 1 || INIT_CYC < 8) begin : g_bad_params
    $error("RESET_MIN_CYC must be >= 1 and INIT_CYC >= 8");
  end

  // Saturating increment shared by both counters
  function automatic logic [31:0] inc_sat(input logic [31:0] cnt, input logic [31:0] lim);
    inc_sat = (cnt >= lim) ? lim : cnt + 32'h1;
  endfunction

  localparam logic [31:0] RST_LIM = 32'(RESET_MIN_CYC);
  localparam logic [31:0] INIT_LIM = 32'(INIT_CYC - 1);

  sideband_pins_t pin1_q, pin2_q;
  logic tg1_q, tg2_q, tg3_q, fault_q;
  logic [31:0] low_cnt_q, init_cnt_q;
  seq_state_t state_q;
  logic nr_q, cfg_rst_q, hp_q, int_q, int_o_q, prs_o_q, prs_oe_q;
  logic read_toggle, clr_pulse, fire, done, fault_rise;
  status_t status_q;

  // ----------------------------------------------------------------
  // Pin and event synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pin1_q <= '1;
      pin2_q <= '1;
      tg1_q <= 1'b0;
      tg2_q <= 1'b0;
      tg3_q <= 1'b0;
    end else begin
      pin1_q <= i_pins;
      pin2_q <= pin1_q;
      tg1_q <= read_toggle;
      tg2_q <= tg1_q;
      tg3_q <= tg2_q;
    end
  end

  // Event decodes for the sequencer and the interrupt latch
  assign clr_pulse = tg2_q ^ tg3_q;
  assign fire = !pin2_q.module_reset_n && (low_cnt_q == RST_LIM);
  assign done = (state_q == ST_RESETTING) && pin2_q.module_reset_n && (init_cnt_q == INIT_LIM);
  assign fault_rise = i_fault && !fault_q;

  // ----------------------------------------------------------------
  // Reset pulse length filter
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      low_cnt_q <= 32'h0;
    end else if (pin2_q.module_reset_n) begin
      low_cnt_q <= 32'h0;
    end else begin
      low_cnt_q <= inc_sat(low_cnt_q, RST_LIM + 32'h1);
    end
  end

  // ----------------------------------------------------------------
  // Reset sequencer, starts busy after power-up
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_RESETTING;
      init_cnt_q <= 32'h0;
      nr_q <= 1'b1;
      cfg_rst_q <= 1'b1;
    end else begin
      case (state_q)
        ST_RESETTING: begin
          if (!pin2_q.module_reset_n) begin
            init_cnt_q <= 32'h0;
          end else if (done) begin
            state_q <= ST_READY;
            nr_q <= 1'b0;
            cfg_rst_q <= 1'b0;
          end else begin
            init_cnt_q <= inc_sat(init_cnt_q, INIT_LIM);
          end
        end
        ST_READY: begin
          if (fire) begin
            state_q <= ST_RESETTING;
            init_cnt_q <= 32'h0;
            nr_q <= 1'b1;
            cfg_rst_q <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_RESETTING;
          nr_q <= 1'b1;
          cfg_rst_q <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Power cap
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      hp_q <= 1'b0;
    end else begin
      hp_q <= !pin2_q.low_power_select && (state_q == ST_READY);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt latch, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      fault_q <= 1'b0;
      int_q <= 1'b0;
    end else begin
      fault_q <= i_fault;
      if (done || fault_rise) begin
        int_q <= 1'b1;
      end else if (clr_pulse) begin
        int_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Open-drain levels and presence
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      int_o_q <= 1'b0;
      prs_o_q <= 1'b0;
      prs_oe_q <= 1'b1;
    end else begin
      int_o_q <= 1'b0;
      prs_o_q <= 1'b0;
      prs_oe_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Status offered to the host
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      status_q <= '0;
    end else begin
      status_q.resetting <= cfg_rst_q;
      status_q.fault <= fault_q;
      status_q.low_power <= pin2_q.low_power_select;
      status_q.not_ready <= nr_q;
    end
  end

  // Two-wire target on the link clock
  sideband_link u_link (
    .i_scl(i_scl),
    .i_rst(i_rst),
    .i_sda(i_sda),
    .i_module_select_n(i_pins.module_select_n),
    .o_sda_o(o_sda_o),
    .o_sda_oe(o_sda_oe),
    .i_status(status_q),
    .o_read_toggle(read_toggle)
  );

  // Outputs straight from their flops
  assign o_module_interrupt_o = int_o_q;
  assign o_module_interrupt_oe = int_q;
  assign o_module_present_o = prs_o_q;
  assign o_module_present_oe = prs_oe_q;
  assign o_settings_reset = cfg_rst_q;
  assign o_high_power_en = hp_q;
  assign o_data_not_ready = nr_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence s_done;
    o_data_not_ready ##1 !o_data_not_ready;
  endsequence
  sequence s_fire;
    (state_q == ST_READY) && fire;
  endsequence

  property p_done_int;
    s_done |-> o_module_interrupt_oe;
  endproperty
  a_done_int: assert property (p_done_int) else $error("completion without interrupt");
  property p_fire_reset;
    s_fire |=> o_data_not_ready && o_settings_reset;
  endproperty
  a_fire_reset: assert property (p_fire_reset) else $error("long reset not honoured");
  property p_short_low;
    (state_q == ST_READY) && !pin2_q.module_reset_n && (low_cnt_q < RST_LIM) |=> !o_data_not_ready;
  endproperty
  a_short_low: assert property (p_short_low) else $error("short pulse reset module");
  property p_init_len;
    $rose(o_data_not_ready) |-> o_data_not_ready [*8];
  endproperty
  a_init_len: assert property (p_init_len) else $error("reset busy too short");
  property p_power_cap;
    pin2_q.low_power_select |=> !o_high_power_en;
  endproperty
  a_power_cap: assert property (p_power_cap) else $error("power cap ignored");
  property p_present;
    o_module_present_oe && !o_module_present_o;
  endproperty
  a_present: assert property (p_present) else $error("presence not grounded");
  property p_fault_int;
    fault_rise |=> o_module_interrupt_oe;
  endproperty
  a_fault_int: assert property (p_fault_int) else $error("fault not flagged");
  property p_int_low_only;
    !o_module_interrupt_o;
  endproperty
  a_int_low_only: assert property (p_int_low_only) else $error("interrupt driven high");
  property p_int_clear;
    clr_pulse && !done && !fault_rise |=> !o_module_interrupt_oe;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("interrupt not cleared");
  property p_int_hold;
    o_module_interrupt_oe && !clr_pulse |=> o_module_interrupt_oe;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt dropped");
endmodule // optical_module_sideband_ctrl
`default_nettype wire

// *** optical_module_sideband_ctrl_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module optical_module_sideband_ctrl_tb_top;
  import optical_sideband_pkg::*;
  // ----------
  // Bench signals
  // ----------
  localparam int RMIN = 4;
  localparam int INIT = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rst_n_pin = 1'b1;
  logic lp = 1'b0;
  logic fault = 1'b0;
  wire logic scl, sel_n, sda, sda_o, sda_oe, int_o, int_oe, prs_o, prs_oe, set_rst, hp, nr;
  logic ack;
  logic [7:0] d;
  int mismatches = 0;
  int samples_checked = 0;
  sideband_pins_t pins;
  // Pin levels with host pull-ups
  assign pins = {sel_n, rst_n_pin, lp};
  wire int_w = int_oe ? int_o : 1'b1;
  wire prs_w = prs_oe ? prs_o : 1'b1;

  // Core clock, 25 ns
  always #12.5 clk = ~clk;

  host_board_model host (.o_scl(scl), .o_select_n(sel_n), .o_sda(sda),
    .i_sda_dev_o(sda_o), .i_sda_dev_oe(sda_oe));
  optical_module_sideband_ctrl #(.RESET_MIN_CYC(RMIN), .INIT_CYC(INIT)) uut (
    .i_core_clk(clk), .i_rst(rst), .i_pins(pins), .i_scl(scl), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_module_interrupt_o(int_o),
    .o_module_interrupt_oe(int_oe), .o_module_present_o(prs_o),
    .o_module_present_oe(prs_oe), .i_fault(fault), .o_settings_reset(set_rst),
    .o_high_power_en(hp), .o_data_not_ready(nr));

  // ----------
  // Helpers
  // ----------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Bounded wait for the not-ready level to fall
  task automatic wait_ready();
    int n;
    n = 0;
    while (nr !== 1'b0 && n < 300) begin
      tick(1);
      n++;
    end
    if (n >= 300) begin
      mismatches++;
      $display("BAD %0t ready never came", $time);
      close_out();
    end
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic t_power();
    chk(nr, 1, "not ready in reset");
    chk(set_rst, 1, "defaults in reset");
    chk(int_w, 1, "int idle in reset");
    chk(prs_w, 0, "presence");
    chk(sda, 1, "data idle");
    rst = 1'b0;
    wait_ready();
    chk(int_w, 0, "power-up int");
    tick(2);
    chk(set_rst, 0, "defaults released");
    chk(hp, 1, "full power");
    $display("t_power done");
  endtask

  task automatic t_read();
    host.frame(1'b1, 8'ha1, 8'h00, ack, d);
    chk(ack, 1, "addr ack");
    chk(d, 8'h00, "ready status");
    tick(2);
    chk(int_w, 1, "int released");
    $display("t_read done");
  endtask

  task automatic t_lp();
    lp = 1'b1;
    tick(5);
    chk(hp, 0, "power capped");
    host.frame(1'b1, 8'ha1, 8'h00, ack, d);
    chk(d, 8'h02, "low power bit");
    tick(1);
    lp = 1'b0;
    tick(5);
    chk(hp, 1, "power restored");
    $display("t_lp done");
  endtask

  task automatic t_fault();
    fault = 1'b1;
    tick(1);
    chk(int_w, 0, "fault int");
    chk(int_o, 0, "int pulls low only");
    host.frame(1'b0, 8'ha1, 8'h00, ack, d);
    chk(ack, 0, "unselected ack");
    chk(d, 8'hff, "unselected data");
    host.frame(1'b1, 8'ha3, 8'h00, ack, d);
    chk(ack, 0, "foreign address");
    host.frame(1'b1, 8'ha0, 8'h5a, ack, d);
    chk(ack, 1, "write ack");
    tick(2);
    chk(int_w, 0, "int held");
    host.frame(1'b1, 8'ha1, 8'h00, ack, d);
    chk(d, 8'h04, "fault bit");
    tick(2);
    chk(int_w, 1, "int cleared");
    fault = 1'b0;
    $display("t_fault done");
  endtask

  task automatic t_reset();
    rst_n_pin = 1'b0;
    tick(RMIN);
    rst_n_pin = 1'b1;
    tick(8);
    chk(nr, 0, "short pulse");
    rst_n_pin = 1'b0;
    tick(RMIN + 8);
    chk(nr, 1, "reset taken");
    chk(set_rst, 1, "defaults restored");
    chk(hp, 0, "power off");
    rst_n_pin = 1'b1;
    wait_ready();
    chk(int_w, 0, "completion int");
    host.frame(1'b1, 8'ha1, 8'h00, ack, d);
    chk(d, 8'h00, "status after reset");
    $display("t_reset done");
  endtask

  // Main sequence: 8 cycles of reset, then each scenario
  initial begin
    tick(8);
    t_power();
    t_read();
    t_lp();
    t_fault();
    t_reset();
    close_out();
  end
endmodule // optical_module_sideband_ctrl_tb_top
`default_nettype wire

// *** optical_sideband_cfg.svh ***
`ifndef OPTICAL_SIDEBAND_CFG_SVH
`define OPTICAL_SIDEBAND_CFG_SVH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SB_CORE_CLK_KHZ 40000
`define SB_RESET_MIN_NS 2000
`define SB_INIT_TIME_US 2000
`define SB_RESET_MIN_CYC ((`SB_RESET_MIN_NS * `SB_CORE_CLK_KHZ + 999999) / 1000000)
`define SB_INIT_CYC ((`SB_INIT_TIME_US * `SB_CORE_CLK_KHZ) / 1000)
// ----------------------------------------------------------------
// Two-wire target
// ----------------------------------------------------------------
`define SB_DEV_ADDR 7'h50
`define SB_ACK_SLOT 4'h8
`define SB_BIT_LAST 4'h7
`define SB_BIT_ZERO 4'h0
`define SB_BIT_ONE 4'h1
`define SB_ADDR_MSB 7
`define SB_ADDR_LSB 1
`define SB_RW_BIT 0
`define SB_STAT_PAD 4'h0
`endif

// *** optical_sideband_pkg.sv ***
`default_nettype none
package optical_sideband_pkg;
  // Reset sequencer states
  typedef enum logic [1:0] {
    ST_RESETTING = 2'b00,
    ST_READY = 2'b01
  } seq_state_t;

  // Status levels offered to the two-wire side
  typedef struct packed {
    logic resetting;
    logic fault;
    logic low_power;
    logic not_ready;
  } status_t;

  // Host-driven sideband pins
  typedef struct packed {
    logic module_select_n;
    logic module_reset_n;
    logic low_power_select;
  } sideband_pins_t;
endpackage
`default_nettype wire

// *** sideband_link.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "optical_sideband_cfg.svh"
module sideband_link (
  // Link clock and reset
  input wire logic i_scl,
  input wire logic i_rst,
  // Link pins
  input wire logic i_sda,
  input wire logic i_module_select_n,
  output logic o_sda_o,
  output logic o_sda_oe,
  // Core side
  input wire optical_sideband_pkg::status_t i_status,
  output logic o_read_toggle
);
  import optical_sideband_pkg::*;

  logic sel1_q, sel2_q;
  status_t st1_q, st2_q;
  logic [3:0] bit_cnt_q;
  logic addr_phase_q, match_q, rd_q;
  logic [7:0] shift_q, stat_byte_q;
  logic tog_q, sda_oe_q, sda_o_q;

  // Address byte match, shared by framing and the ack drive
  function automatic logic addr_hit(input logic [7:0] b);
    addr_hit = (b[`SB_ADDR_MSB:`SB_ADDR_LSB] == `SB_DEV_ADDR);
  endfunction

  // ----------------------------------------------------------------
  // Synchronisers into the link domain
  // ----------------------------------------------------------------
  always_ff @(posedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      sel1_q <= 1'b1;
      sel2_q <= 1'b1;
      st1_q <= '0;
      st2_q <= '0;
    end else begin
      sel1_q <= i_module_select_n;
      sel2_q <= sel1_q;
      st1_q <= i_status;
      st2_q <= st1_q;
    end
  end

  // ----------------------------------------------------------------
  // Bit framing, address match and read-done event
  // ----------------------------------------------------------------
  always_ff @(posedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      bit_cnt_q <= `SB_BIT_ZERO;
      addr_phase_q <= 1'b1;
      match_q <= 1'b0;
      rd_q <= 1'b0;
      shift_q <= 8'h00;
      stat_byte_q <= 8'h00;
      tog_q <= 1'b0;
    end else if (sel2_q) begin
      bit_cnt_q <= `SB_BIT_ZERO;
      addr_phase_q <= 1'b1;
      match_q <= 1'b0;
    end else if (bit_cnt_q != `SB_ACK_SLOT) begin
      shift_q <= {shift_q[6:0], i_sda};
      bit_cnt_q <= bit_cnt_q + `SB_BIT_ONE;
    end else begin
      bit_cnt_q <= `SB_BIT_ZERO;
      if (addr_phase_q) begin
        match_q <= addr_hit(shift_q);
        rd_q <= shift_q[`SB_RW_BIT];
        addr_phase_q <= 1'b0;
        stat_byte_q <= {`SB_STAT_PAD, st2_q};
      end else if (match_q && rd_q) begin
        tog_q <= ~tog_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data line drive, changed while the clock is low
  // ----------------------------------------------------------------
  always_ff @(negedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      sda_oe_q <= 1'b0;
      sda_o_q <= 1'b0;
    end else if (sel2_q) begin
      sda_oe_q <= 1'b0;
    end else if (bit_cnt_q == `SB_ACK_SLOT) begin
      sda_oe_q <= addr_phase_q ? addr_hit(shift_q) : (match_q && !rd_q);
    end else if (!addr_phase_q && match_q && rd_q) begin
      sda_oe_q <= ~stat_byte_q[3'(`SB_BIT_LAST - bit_cnt_q)];
    end else begin
      sda_oe_q <= 1'b0;
    end
  end

  // Outputs straight from the link flops
  assign o_sda_oe = sda_oe_q;
  assign o_sda_o = sda_o_q;
  assign o_read_toggle = tog_q;
endmodule // sideband_link
`default_nettype wire
